//--- mise_pkg.sv
// Opcode, flag and timing constants for the instruction subset executor
package mise_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 10;
  // Instruction subset selector codes (ordinal, fed by the decoder in front)
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_MOVE_ACC_TO_FILE = 4'h1,
    OP_SUBROUTINE_EXIT = 4'h2,
    OP_EXIT_WITH_LITERAL = 4'h3,
    OP_ROTATE_LEFT_CARRY = 4'h4,
    OP_ROTATE_RIGHT_CARRY = 4'h5,
    OP_LOW_POWER = 4'h6,
    OP_LITERAL_MINUS_ACC = 4'h7,
    OP_FILE_MINUS_ACC = 4'h8,
    OP_NIBBLE_EXCHANGE = 4'h9,
    OP_XOR_LITERAL_ACC = 4'hA,
    OP_XOR_FILE_ACC = 4'hB
  } mise_op_e;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESCALE_CLEAR = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic POWERDOWN_RESET = 1'b1;
  localparam int RETURN_CYCLES = 2;
endpackage

//--- mise_file_if.sv
// File register port between executor and file memory
`timescale 1ns/10ps
interface mise_file_if;
  logic [6:0] addr;
  logic [7:0] rdata;
  logic wen;
  logic [7:0] wdata;
  modport core (output addr, output wen, output wdata, input rdata);
  modport mem (input addr, input wen, input wdata, output rdata);
endinterface

//--- mise_file_mem.sv
// File register memory, registered read data
`timescale 1ns/10ps
module mise_file_mem #(
  parameter int DEPTH = 128
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access port
  mise_file_if.mem port
);
  import mise_pkg::*;
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_r;
  always_ff @(posedge clk) begin
    if (port.wen) begin
      mem[port.addr] <= port.wdata;
    end
  end
  // Read-before-write so a same-cycle store does not bypass
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= FILE_RESET;
    end else begin
      rdata_r <= mem[port.addr];
    end
  end
  assign port.rdata = rdata_r;
endmodule // mise_file_mem

//--- mise_exec.sv
// Executor for a subset of an 8-bit core's instructions
`timescale 1ns/10ps
module mise_exec #(
  parameter int PC_WIDTH = mise_pkg::PC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire mise_pkg::mise_op_e instOp,
  input wire logic [6:0] instFile,
  input wire logic [7:0] instLiteral,
  input wire logic instDest,
  input wire logic instValid,
  output logic instReady,
  // Return stack
  input wire logic [PC_WIDTH-1:0] stackTop,
  output logic stackPop,
  // Program counter load
  output logic [PC_WIDTH-1:0] pcLoadValue,
  output logic pcLoad,
  // Sleep and wake
  input wire logic wakeUp,
  output logic sleeping,
  output logic oscEnable,
  // Architectural state
  output logic [7:0] acc,
  output logic carryFlag,
  output logic halfByteCarry,
  output logic zeroFlag,
  output logic timeoutFlagN,
  output logic powerdownFlagN,
  output logic [7:0] watchdogCount,
  output logic [7:0] watchdogPrescale
);
  import mise_pkg::*;

  typedef enum logic [3:0] {
    ST_ISSUE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_RETURN = 4'b0100,
    ST_SLEEP = 4'b1000
  } mise_state_e;

  mise_file_if fport ();
  mise_file_mem u_mem (
    .clk(clk),
    .rst(rst),
    .port(fport)
  );

  mise_state_e state_r, state_nxt;
  mise_op_e op_r, op_nxt;
  logic [6:0] file_r, file_nxt;
  logic [7:0] lit_r, lit_nxt;
  logic dest_r, dest_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
  logic tf_r, tf_nxt, pf_r, pf_nxt;
  logic [7:0] wdt_r, wdt_nxt, pre_r, pre_nxt;
  logic [PC_WIDTH-1:0] pc_r, pc_nxt;
  logic pcLoad_r, pcLoad_nxt;
  logic [7:0] operand, result;
  logic [8:0] diff;
  logic [4:0] diffLow;
  logic fileOp;

  // Operations that read a file register need one extra cycle for the registered memory read
  assign fileOp = (instOp == OP_ROTATE_LEFT_CARRY) || (instOp == OP_ROTATE_RIGHT_CARRY)
    || (instOp == OP_FILE_MINUS_ACC) || (instOp == OP_NIBBLE_EXCHANGE)
    || (instOp == OP_XOR_FILE_ACC);

  always_comb begin
    operand = fport.rdata;
    if (op_r == OP_LITERAL_MINUS_ACC || op_r == OP_XOR_LITERAL_ACC) begin
      operand = lit_r;
    end
    // Two's complement add: operand + ~acc + 1, carry out means no borrow
    diff = {1'b0, operand} + {1'b0, ~acc_r} + 9'h001;
    diffLow = {1'b0, operand[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
  end

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    file_nxt = file_r;
    lit_nxt = lit_r;
    dest_nxt = dest_r;
    acc_nxt = acc_r;
    c_nxt = c_r;
    dc_nxt = dc_r;
    z_nxt = z_r;
    tf_nxt = tf_r;
    pf_nxt = pf_r;
    wdt_nxt = wdt_r;
    pre_nxt = pre_r;
    pc_nxt = pc_r;
    pcLoad_nxt = 1'b0;
    result = 8'h00;
    fport.addr = instFile;
    fport.wen = 1'b0;
    fport.wdata = acc_r;
    stackPop = 1'b0;
    instReady = 1'b0;
    case (state_r)
      ST_ISSUE: begin
        instReady = 1'b1;
        if (instValid) begin
          op_nxt = instOp;
          file_nxt = instFile;
          lit_nxt = instLiteral;
          dest_nxt = instDest;
          case (instOp)
            OP_MOVE_ACC_TO_FILE: begin
              fport.wen = 1'b1;
            end
            OP_SUBROUTINE_EXIT: begin
              stackPop = 1'b1;
              pc_nxt = stackTop;
              pcLoad_nxt = 1'b1;
              state_nxt = ST_RETURN;
            end
            OP_EXIT_WITH_LITERAL: begin
              stackPop = 1'b1;
              pc_nxt = stackTop;
              pcLoad_nxt = 1'b1;
              acc_nxt = instLiteral;
              state_nxt = ST_RETURN;
            end
            OP_LOW_POWER: begin
              wdt_nxt = WATCHDOG_CLEAR;
              pre_nxt = PRESCALE_CLEAR;
              tf_nxt = 1'b1;
              pf_nxt = 1'b0;
              state_nxt = ST_SLEEP;
            end
            OP_LITERAL_MINUS_ACC, OP_XOR_LITERAL_ACC: begin
              state_nxt = ST_FETCH;
            end
            default: begin
              if (fileOp) begin
                state_nxt = ST_FETCH;
              end
            end
          endcase
        end
      end
      ST_FETCH: begin
        fport.addr = file_r;
        state_nxt = ST_ISSUE;
        case (op_r)
          OP_ROTATE_LEFT_CARRY: begin
            result = {operand[6:0], c_r};
            c_nxt = operand[7];
          end
          OP_ROTATE_RIGHT_CARRY: begin
            result = {c_r, operand[7:1]};
            c_nxt = operand[0];
          end
          OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC: begin
            result = diff[7:0];
            c_nxt = diff[8];
            dc_nxt = diffLow[4];
            z_nxt = (diff[7:0] == 8'h00);
          end
          OP_NIBBLE_EXCHANGE: begin
            result = {operand[3:0], operand[7:4]};
          end
          OP_XOR_LITERAL_ACC, OP_XOR_FILE_ACC: begin
            result = operand ^ acc_r;
            z_nxt = (result == 8'h00);
          end
          default: begin
            result = acc_r;
          end
        endcase
        // Literal forms always land in the accumulator
        if (op_r == OP_LITERAL_MINUS_ACC || op_r == OP_XOR_LITERAL_ACC
            || dest_r == DEST_ACC) begin
          acc_nxt = result;
        end else begin
          fport.wen = 1'b1;
          fport.wdata = result;
        end
      end
      ST_RETURN: begin
        // Second cycle of a return slot, no effect
        state_nxt = ST_ISSUE;
      end
      ST_SLEEP: begin
        if (wakeUp) begin
          state_nxt = ST_ISSUE;
        end
      end
      default: begin
        state_nxt = ST_ISSUE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_ISSUE;
      op_r <= OP_NOP;
      file_r <= 7'h00;
      lit_r <= 8'h00;
      dest_r <= DEST_ACC;
      acc_r <= ACC_RESET;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
      tf_r <= TIMEOUT_RESET;
      pf_r <= POWERDOWN_RESET;
      wdt_r <= WATCHDOG_CLEAR;
      pre_r <= PRESCALE_CLEAR;
      pc_r <= '0;
      pcLoad_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      file_r <= file_nxt;
      lit_r <= lit_nxt;
      dest_r <= dest_nxt;
      acc_r <= acc_nxt;
      c_r <= c_nxt;
      dc_r <= dc_nxt;
      z_r <= z_nxt;
      tf_r <= tf_nxt;
      pf_r <= pf_nxt;
      wdt_r <= wdt_nxt;
      pre_r <= pre_nxt;
      pc_r <= pc_nxt;
      pcLoad_r <= pcLoad_nxt;
    end
  end

  assign acc = acc_r;
  assign carryFlag = c_r;
  assign halfByteCarry = dc_r;
  assign zeroFlag = z_r;
  assign timeoutFlagN = tf_r;
  assign powerdownFlagN = pf_r;
  assign watchdogCount = wdt_r;
  assign watchdogPrescale = pre_r;
  assign pcLoadValue = pc_r;
  assign pcLoad = pcLoad_r;
  assign sleeping = (state_r == ST_SLEEP);
  assign oscEnable = (state_r != ST_SLEEP);
endmodule // mise_exec

//--- mise_exec_checker.sv
// Assertions on the executor ports
`timescale 1ns/10ps
module mise_exec_checker #(
  parameter int PC_WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Issue
  input wire mise_pkg::mise_op_e instOp,
  input wire logic instValid,
  input wire logic instReady,
  input wire logic [7:0] instLiteral,
  // Return and sleep
  input wire logic [PC_WIDTH-1:0] stackTop,
  input wire logic stackPop,
  input wire logic pcLoad,
  input wire logic [PC_WIDTH-1:0] pcLoadValue,
  input wire logic wakeUp,
  input wire logic sleeping,
  input wire logic oscEnable,
  // State
  input wire logic [7:0] acc,
  input wire logic carryFlag,
  input wire logic zeroFlag,
  input wire logic timeoutFlagN,
  input wire logic powerdownFlagN,
  input wire logic [7:0] watchdogCount,
  input wire logic [7:0] watchdogPrescale
);
  import mise_pkg::*;
  logic take;
  logic ret;
  assign take = instValid && instReady;
  assign ret = take && (instOp == OP_SUBROUTINE_EXIT || instOp == OP_EXIT_WITH_LITERAL);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_move_flags_kept: assert property (
    take && instOp == OP_MOVE_ACC_TO_FILE |=> $stable({carryFlag, zeroFlag}))
    else $error("move changed flags");
  a_return_pops: assert property (
    ret |-> stackPop ##1 pcLoad && pcLoadValue == $past(stackTop))
    else $error("return load wrong");
  a_return_two_cycles: assert property (
    ret |=> !instReady ##1 instReady)
    else $error("return length wrong");
  a_literal_exit_acc: assert property (
    take && instOp == OP_EXIT_WITH_LITERAL |-> ##2 acc == $past(instLiteral, 2))
    else $error("literal return acc wrong");
  a_xor_literal_result: assert property (
    take && instOp == OP_XOR_LITERAL_ACC |-> ##2 acc == ($past(acc, 2) ^ $past(instLiteral, 2))
    && zeroFlag == (acc == 8'h00) && $stable(carryFlag))
    else $error("xor literal wrong");
  a_sub_literal_result: assert property (
    take && instOp == OP_LITERAL_MINUS_ACC |-> ##2 acc == 8'($past(instLiteral, 2) - $past(acc, 2))
    && carryFlag == ($past(instLiteral, 2) >= $past(acc, 2)))
    else $error("subtract literal wrong");
  a_sleep_entry: assert property (
    take && instOp == OP_LOW_POWER |=> sleeping && !oscEnable && timeoutFlagN && !powerdownFlagN
    && watchdogCount == 8'h00 && watchdogPrescale == 8'h00)
    else $error("sleep entry wrong");
  a_sleep_holds: assert property (
    sleeping && !wakeUp |=> sleeping && !instReady)
    else $error("left sleep early");
  cp_sleep: cover property (take && instOp == OP_LOW_POWER);
  cp_return: cover property (ret);
  cp_file_sub: cover property (take && instOp == OP_FILE_MINUS_ACC);
endmodule // mise_exec_checker

//--- test_mise_exec.sv
// Directed bench for the instruction subset executor
`timescale 1ns/10ps
module test_mise_exec;
  import mise_pkg::*;
  logic clk = 1'b0, rst = 1'b1, instValid = 1'b0, instDest = 1'b0, wakeUp = 1'b0;
  mise_op_e instOp = OP_NOP;
  logic [6:0] instFile = 7'h00;
  logic [7:0] instLiteral = 8'h00;
  logic [9:0] stackTop = 10'h2A7;
  logic instReady, stackPop, pcLoad, sleeping, oscEnable, carryFlag, halfByteCarry, zeroFlag;
  logic timeoutFlagN, powerdownFlagN;
  logic [9:0] pcLoadValue;
  logic [7:0] acc, watchdogCount, watchdogPrescale;
  int err_count = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  mise_exec DUT (.clk(clk), .rst(rst), .instOp(instOp), .instFile(instFile),
    .instLiteral(instLiteral), .instDest(instDest), .instValid(instValid),
    .instReady(instReady), .stackTop(stackTop), .stackPop(stackPop),
    .pcLoadValue(pcLoadValue), .pcLoad(pcLoad), .wakeUp(wakeUp), .sleeping(sleeping),
    .oscEnable(oscEnable), .acc(acc), .carryFlag(carryFlag), .halfByteCarry(halfByteCarry),
    .zeroFlag(zeroFlag), .timeoutFlagN(timeoutFlagN), .powerdownFlagN(powerdownFlagN),
    .watchdogCount(watchdogCount), .watchdogPrescale(watchdogPrescale));
  task automatic results();
    $display("mismatches %0d of %0d checks", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(instReady || sleeping) && n < 20);
    if (!(instReady || sleeping)) begin
      err_count++;
      results();
    end
  endtask
  // Request held until the edge that sees ready, then dropped
  task automatic run(input mise_op_e o, input logic [6:0] f, input logic [7:0] k, input logic d);
    @(posedge clk);
    instOp <= o;
    instFile <= f;
    instLiteral <= k;
    instDest <= d;
    instValid <= 1'b1;
    wait_ready();
    @(posedge clk);
    instValid <= 1'b0;
    wait_ready();
  endtask
  task automatic sc_return();
    run(OP_EXIT_WITH_LITERAL, 7'h00, 8'hA5, 1'b0);
    chk(10'(acc), 10'h0A5);
    chk(pcLoadValue, 10'h2A7);
    // Fresh stack top, so a missed second load cannot pass
    @(posedge clk);
    stackTop <= 10'h15A;
    run(OP_SUBROUTINE_EXIT, 7'h00, 8'h00, 1'b0);
    chk(pcLoadValue, 10'h15A);
  endtask
  // File memory is undefined after reset, so it is written first
  task automatic sc_file();
    run(OP_MOVE_ACC_TO_FILE, 7'h7F, 8'h00, 1'b0);
    run(OP_XOR_FILE_ACC, 7'h7F, 8'h00, 1'b0);
    chk(10'({acc, zeroFlag}), 10'h001);
    run(OP_NIBBLE_EXCHANGE, 7'h7F, 8'h00, 1'b0);
    chk(10'({acc, zeroFlag}), 10'h0B5);
  endtask
  task automatic sc_sub();
    run(OP_LITERAL_MINUS_ACC, 7'h00, 8'h50, 1'b0);
    chk(10'({acc, carryFlag, halfByteCarry}), 10'h3D8);
    run(OP_LITERAL_MINUS_ACC, 7'h00, 8'hFF, 1'b0);
    chk(10'({acc, carryFlag, halfByteCarry}), 10'h027);
  endtask
  task automatic sc_rotate();
    run(OP_ROTATE_LEFT_CARRY, 7'h7F, 8'h00, 1'b1);
    chk(10'({acc, carryFlag}), 10'h013);
    run(OP_ROTATE_RIGHT_CARRY, 7'h7F, 8'h00, 1'b0);
    chk(10'({acc, carryFlag}), 10'h14B);
    run(OP_FILE_MINUS_ACC, 7'h7F, 8'h00, 1'b1);
    chk(10'({acc, carryFlag, halfByteCarry, zeroFlag}), 10'h52A);
    run(OP_NIBBLE_EXCHANGE, 7'h7F, 8'h00, 1'b0);
    chk(10'({acc, carryFlag}), 10'h0D4);
    run(OP_ROTATE_LEFT_CARRY, 7'h7F, 8'h00, 1'b0);
    chk(10'({acc, carryFlag}), 10'h099);
    run(OP_XOR_LITERAL_ACC, 7'h00, 8'h4C, 1'b0);
    chk(10'({acc, carryFlag, zeroFlag}), 10'h003);
  endtask
  task automatic sc_sleep();
    run(OP_LOW_POWER, 7'h00, 8'h00, 1'b0);
    chk(10'({sleeping, oscEnable, timeoutFlagN, powerdownFlagN}), 10'h00A);
    chk(10'(watchdogCount), 10'h000);
    chk(10'(watchdogPrescale), 10'h000);
    // Request held through sleep until the first ready edge after wake
    @(posedge clk);
    instOp <= OP_NOP;
    instValid <= 1'b1;
    repeat (4) @(negedge clk);
    chk(10'({sleeping, instReady}), 10'h002);
    @(posedge clk);
    wakeUp <= 1'b1;
    @(posedge clk);
    wakeUp <= 1'b0;
    @(negedge clk);
    chk(10'({sleeping, oscEnable, instReady}), 10'h003);
    @(posedge clk);
    instValid <= 1'b0;
    @(negedge clk);
    chk(10'({sleeping, instReady}), 10'h001);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    sc_return();
    sc_file();
    sc_sub();
    sc_rotate();
    sc_sleep();
    results();
  end
endmodule // test_mise_exec
bind mise_exec mise_exec_checker #(.PC_WIDTH(PC_WIDTH)) chkI (.clk(clk), .rst(rst),
  .instOp(instOp), .instValid(instValid), .instReady(instReady), .instLiteral(instLiteral),
  .stackTop(stackTop), .stackPop(stackPop), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
  .wakeUp(wakeUp), .sleeping(sleeping), .oscEnable(oscEnable), .acc(acc),
  .carryFlag(carryFlag), .zeroFlag(zeroFlag), .timeoutFlagN(timeoutFlagN),
  .powerdownFlagN(powerdownFlagN), .watchdogCount(watchdogCount),
  .watchdogPrescale(watchdogPrescale));
